// ==== verilog/sfcf_pkg.sv ====
// constants, opcode table and decode functions for the serial flash command framer
package sfcf_pkg;

    // ==========================================================
    // timing
    localparam int unsigned SYS_CLK_HZ = 10_000_000;
    localparam int unsigned SELECT_DELAY_MS = 1;
    localparam int unsigned WRITE_INHIBIT_MS = 20;
    // least time: round up to whole cycles
    localparam int unsigned SELECT_DELAY_CYC = (SELECT_DELAY_MS * SYS_CLK_HZ + 999) / 1000;
    // longest time: round down
    localparam int unsigned WRITE_INHIBIT_CYC = (WRITE_INHIBIT_MS * SYS_CLK_HZ) / 1000;

    // ==========================================================
    // frame layout
    localparam int unsigned OP_W = 8;
    localparam int unsigned ADDR_W = 24;
    localparam int unsigned PAGE_W = 9;
    localparam int unsigned COL_W = 9;
    localparam int unsigned PAGE_MSB = 17;
    localparam int unsigned PAGE_LSB = 9;
    localparam int unsigned COL_MSB = 8;
    localparam int unsigned COL_LSB = 0;
    localparam int unsigned BLOCK_KEEP = 5;
    localparam int unsigned PAGE_BYTES = 264;
    localparam int unsigned CNT_W = 6;
    localparam logic [CNT_W-1:0] LAST_OP_BIT = 6'h07;
    localparam logic [CNT_W-1:0] LAST_ADDR_BIT = 6'h17;
    localparam logic [2:0] LAST_DATA_BIT = 3'h7;

    // ==========================================================
    // pin reset levels: select seen low and clock high until the pins are sampled
    localparam logic CS_SYNC_RST = 1'b1;
    localparam logic SCK_SYNC_RST = 1'b1;
    localparam logic SI_SYNC_RST = 1'b0;

    // ==========================================================
    // opcodes
    localparam logic [7:0] OP_READ_PAGE = 8'h03;
    localparam logic [7:0] OP_READ_FAST = 8'h0b;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
    localparam logic [7:0] OP_PAGE_TO_BUF = 8'h53;
    localparam logic [7:0] OP_AUTO_REWRITE = 8'h58;
    localparam logic [7:0] OP_PAGE_COMPARE = 8'h60;
    localparam logic [7:0] OP_READ_SECURITY = 8'h77;
    localparam logic [7:0] OP_FREE_ADDR_7C = 8'h7c;
    localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
    localparam logic [7:0] OP_WRITE_THROUGH = 8'h82;
    localparam logic [7:0] OP_BUF_TO_PAGE_ERASE = 8'h83;
    localparam logic [7:0] OP_BUF_WRITE = 8'h84;
    localparam logic [7:0] OP_BUF_TO_PAGE = 8'h88;
    localparam logic [7:0] OP_READ_ID = 8'h9f;
    localparam logic [7:0] OP_DEEP_SLEEP = 8'hb9;
    localparam logic [7:0] OP_WAKE = 8'hab;
    localparam logic [7:0] OP_BUF_READ_SLOW = 8'hd1;
    localparam logic [7:0] OP_READ_DIRECT = 8'hd2;
    localparam logic [7:0] OP_BUF_READ = 8'hd4;
    localparam logic [7:0] OP_STATUS = 8'hd7;
    localparam logic [7:0] OP_READ_CONT = 8'he8;

    typedef enum logic [2:0] {
        AK_NONE = 3'b000,
        AK_FULL = 3'b001,
        AK_PAGE = 3'b010,
        AK_COL = 3'b011,
        AK_BLOCK = 3'b100,
        AK_IGNORED = 3'b101
    } sfcf_addr_kind_t;

    // ==========================================================
    // decode
    function automatic sfcf_addr_kind_t sfcf_addr_kind(input logic [7:0] op);
        case (op)
            OP_READ_PAGE, OP_READ_FAST, OP_WRITE_THROUGH, OP_READ_DIRECT, OP_READ_CONT: sfcf_addr_kind = AK_FULL;
            OP_BLOCK_ERASE: sfcf_addr_kind = AK_BLOCK;
            OP_PAGE_TO_BUF, OP_AUTO_REWRITE, OP_PAGE_COMPARE, OP_PAGE_ERASE, OP_BUF_TO_PAGE_ERASE,
            OP_BUF_TO_PAGE: sfcf_addr_kind = AK_PAGE;
            OP_BUF_WRITE, OP_BUF_READ_SLOW, OP_BUF_READ: sfcf_addr_kind = AK_COL;
            OP_READ_SECURITY, OP_FREE_ADDR_7C: sfcf_addr_kind = AK_IGNORED;
            default: sfcf_addr_kind = AK_NONE;
        endcase
    endfunction : sfcf_addr_kind

    function automatic logic [2:0] sfcf_dummy_bytes(input logic [7:0] op);
        case (op)
            OP_READ_FAST, OP_BUF_READ: sfcf_dummy_bytes = 3'h1;
            OP_READ_DIRECT, OP_READ_CONT: sfcf_dummy_bytes = 3'h4;
            default: sfcf_dummy_bytes = 3'h0;
        endcase
    endfunction : sfcf_dummy_bytes

    function automatic logic sfcf_is_read(input logic [7:0] op);
        case (op)
            OP_READ_PAGE, OP_READ_FAST, OP_READ_SECURITY, OP_READ_ID, OP_BUF_READ_SLOW, OP_READ_DIRECT,
            OP_BUF_READ, OP_STATUS, OP_READ_CONT: sfcf_is_read = 1'b1;
            default: sfcf_is_read = 1'b0;
        endcase
    endfunction : sfcf_is_read

    function automatic logic sfcf_takes_data(input logic [7:0] op);
        sfcf_takes_data = (op == OP_BUF_WRITE) || (op == OP_WRITE_THROUGH);
    endfunction : sfcf_takes_data

endpackage : sfcf_pkg

// ==== verilog/sfcf_link_if.sv ====
// internal carrier between the pin sampler, the framer and the output shifter
`timescale 1ns/1ns
interface sfcf_link_if;
    logic csLow;
    logic csFall;
    logic csRise;
    logic sckHigh;
    logic sckRise;
    logic sckFall;
    logic siBit;
    logic load;
    logic [7:0] loadByte;

    modport pins (output csLow, output csFall, output csRise, output sckHigh, output sckRise, output sckFall,
        output siBit);
    modport frame (input csLow, input csFall, input csRise, input sckHigh, input sckRise, input siBit,
        output load, output loadByte);
    modport shift (input csLow, input csRise, input sckRise, input sckFall, input load, input loadByte);
endinterface : sfcf_link_if

// ==== verilog/sfcf_pin_sync.sv ====
// two-flop synchronisers and edge detection for the serial pins
`timescale 1ns/1ns
module sfcf_pin_sync (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic chipSelN,
    input wire logic serClk,
    input wire logic serIn,
    sfcf_link_if.pins link
);
    import sfcf_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] sync;
        logic csLowPrev;
        logic sckPrev;
    } sfcf_sync_t;

    // select resets as low: a select already low at release is no falling edge
    localparam sfcf_sync_t SYNC_RST = '{
        meta: {CS_SYNC_RST, SCK_SYNC_RST, SI_SYNC_RST},
        sync: {CS_SYNC_RST, SCK_SYNC_RST, SI_SYNC_RST},
        csLowPrev: 1'b1,
        sckPrev: SCK_SYNC_RST
    };

    sfcf_sync_t q;
    sfcf_sync_t d;

    always_comb begin
        d = q;
        d.meta = {~chipSelN, serClk, serIn};
        d.sync = q.meta;
        d.csLowPrev = q.sync[2];
        d.sckPrev = q.sync[1];
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= SYNC_RST;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // edges, taken only from the second stage onward
    assign link.csLow = q.sync[2];
    assign link.csFall = q.sync[2] & ~q.csLowPrev;
    assign link.csRise = ~q.sync[2] & q.csLowPrev;
    assign link.sckHigh = q.sync[1];
    assign link.sckRise = q.sync[1] & ~q.sckPrev;
    assign link.sckFall = ~q.sync[1] & q.sckPrev;
    assign link.siBit = q.sync[0];
endmodule : sfcf_pin_sync

// ==== verilog/sfcf_out_shift.sv ====
// serial output shifter: drives read data msb first; a loaded byte appears at once, later bits change on the falling clock
`timescale 1ns/1ns
module sfcf_out_shift (
    input wire logic sys_clk,
    input wire logic sys_rst,
    sfcf_link_if.shift link,
    output logic serOut,
    output logic serOutEnN
);
    import sfcf_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0] sh;
        logic armed;
        logic drive;
    } sfcf_shift_t;

    sfcf_shift_t q;
    sfcf_shift_t d;

    always_comb begin
        d = q;
        if (link.load) begin
            // a fresh byte puts its msb out at once; the host samples it on the next rise
            d.sh = link.loadByte;
            d.armed = 1'b0;
            d.drive = 1'b1;
        end else if (link.sckRise) begin
            d.armed = 1'b1;
        end else if (link.sckFall && q.armed) begin
            d.sh = {q.sh[6:0], 1'b0};
            d.armed = 1'b0;
        end
        if (link.csRise || !link.csLow) begin
            d.drive = 1'b0;
            d.armed = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign serOut = q.sh[7];
    assign serOutEnN = ~q.drive;
endmodule : sfcf_out_shift

// ==== verilog/sfcf_frame.sv ====
// serial flash command framer: opcode, address and dummy framing, power-on state
// ==========================================================
`timescale 1ns/1ns
module sfcf_frame #(
    parameter int unsigned SELECT_DELAY = sfcf_pkg::SELECT_DELAY_CYC,
    parameter int unsigned WRITE_INHIBIT = sfcf_pkg::WRITE_INHIBIT_CYC
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic chipSelN,
    input wire logic serClk,
    input wire logic serIn,
    output logic serOut,
    output logic serOutEnN,
    output logic cmdValid,
    output logic [7:0] cmdOpcode,
    output logic [sfcf_pkg::PAGE_W-1:0] cmdPage,
    output logic [sfcf_pkg::COL_W-1:0] cmdByte,
    input wire logic [7:0] rdByte,
    output logic rdTake,
    output logic wrValid,
    output logic [7:0] wrByte,
    output logic spiMode3,
    output logic deepPowerDown,
    output logic standby,
    output logic selectAllowed,
    output logic writeAllowed
);
    import sfcf_pkg::*;

    localparam int unsigned SEL_W = $clog2(SELECT_DELAY + 1);
    localparam int unsigned WRI_W = $clog2(WRITE_INHIBIT + 1);
    localparam logic [SEL_W-1:0] SEL_LAST = SEL_W'(SELECT_DELAY);
    localparam logic [WRI_W-1:0] WRI_LAST = WRI_W'(WRITE_INHIBIT);

    // ==========================================================
    // state
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OPCODE = 3'b001,
        ST_ADDR = 3'b010,
        ST_DUMMY = 3'b011,
        ST_DATA = 3'b100,
        ST_IGNORE = 3'b101
    } sfcf_state_t;

    typedef struct packed {
        sfcf_state_t st;
        logic [CNT_W-1:0] bitCnt;
        logic [2:0] dummyLeft;
        logic [2:0] dataBit;
        logic [7:0] opc;
        logic [ADDR_W-1:0] addr;
        logic mode3;
        logic dpd;
        logic sleepPend;
        logic wakePend;
        logic cmdValid;
        logic [7:0] cmdOpc;
        logic [PAGE_W-1:0] cmdPage;
        logic [COL_W-1:0] cmdCol;
        logic load;
        logic rdTake;
        logic wrValid;
        logic [7:0] wrSh;
        logic [7:0] wrByte;
        logic [SEL_W-1:0] selCnt;
        logic [WRI_W-1:0] wriCnt;
    } sfcf_frame_t;

    sfcf_frame_t q;
    sfcf_frame_t d;

    sfcf_link_if link ();

    sfcf_pin_sync u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .chipSelN(chipSelN),
        .serClk(serClk),
        .serIn(serIn),
        .link(link.pins)
    );

    sfcf_out_shift u_shift (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .link(link.shift),
        .serOut(serOut),
        .serOutEnN(serOutEnN)
    );

    // ==========================================================
    // helpers
    logic [7:0] opNext;
    logic [ADDR_W-1:0] addrNext;
    sfcf_addr_kind_t kind;
    logic [PAGE_W-1:0] pageField;
    logic [COL_W-1:0] colField;

    assign opNext = {q.opc[6:0], link.siBit};
    assign addrNext = {q.addr[ADDR_W-2:0], link.siBit};
    assign kind = sfcf_addr_kind(q.opc);
    assign pageField = addrNext[PAGE_MSB:PAGE_LSB];
    assign colField = addrNext[COL_MSB:COL_LSB];

    // ==========================================================
    // framing
    always_comb begin
        d = q;
        d.cmdValid = 1'b0;
        d.load = 1'b0;
        d.rdTake = 1'b0;
        d.wrValid = 1'b0;
        // power-on timers only report; honouring them is up to the host
        if (q.selCnt != SEL_LAST) begin
            d.selCnt = q.selCnt + SEL_W'(1);
        end
        if (q.wriCnt != WRI_LAST) begin
            d.wriCnt = q.wriCnt + WRI_W'(1);
        end
        if (link.csRise) begin
            // frames cut before cmdValid are simply dropped; one cut in the dummy or data bytes has already issued its command
            if (q.sleepPend) begin
                d.dpd = 1'b1;
            end
            if (q.wakePend) begin
                d.dpd = 1'b0;
            end
            d.sleepPend = 1'b0;
            d.wakePend = 1'b0;
            d.st = ST_IDLE;
        end else if (link.csFall && q.st == ST_IDLE) begin
            d.mode3 = link.sckHigh;
            d.st = ST_OPCODE;
            d.bitCnt = '0;
        end else if (link.sckRise && link.csLow) begin
            case (q.st)
                ST_OPCODE: begin
                    d.opc = opNext;
                    d.bitCnt = q.bitCnt + CNT_W'(1);
                    if (q.bitCnt == LAST_OP_BIT) begin
                        d.bitCnt = '0;
                        d.dummyLeft = sfcf_dummy_bytes(opNext);
                        d.dataBit = '0;
                        if (q.dpd && opNext != OP_WAKE) begin
                            d.st = ST_IGNORE;
                        end else if (sfcf_addr_kind(opNext) != AK_NONE) begin
                            d.st = ST_ADDR;
                        end else begin
                            // no address bytes follow these opcodes
                            d.cmdValid = 1'b1;
                            d.cmdOpc = opNext;
                            d.cmdPage = '0;
                            d.cmdCol = '0;
                            d.sleepPend = (opNext == OP_DEEP_SLEEP);
                            d.wakePend = (opNext == OP_WAKE);
                            if (sfcf_is_read(opNext)) begin
                                d.st = ST_DATA;
                                d.load = 1'b1;
                                d.rdTake = 1'b1;
                            end else begin
                                d.st = ST_IGNORE;
                            end
                        end
                    end
                end
                ST_ADDR: begin
                    d.addr = addrNext;
                    d.bitCnt = q.bitCnt + CNT_W'(1);
                    if (q.bitCnt == LAST_ADDR_BIT) begin
                        d.bitCnt = '0;
                        d.cmdValid = 1'b1;
                        d.cmdOpc = q.opc;
                        d.cmdPage = pageField;
                        d.cmdCol = colField;
                        case (kind)
                            AK_BLOCK: begin
                                d.cmdPage = {pageField[PAGE_W-1 -: BLOCK_KEEP], (PAGE_W-BLOCK_KEEP)'(0)};
                                d.cmdCol = '0;
                            end
                            AK_PAGE: d.cmdCol = '0;
                            AK_COL: d.cmdPage = '0;
                            AK_IGNORED: begin
                                d.cmdPage = '0;
                                d.cmdCol = '0;
                            end
                            default: begin
                                d.cmdPage = pageField;
                                d.cmdCol = colField;
                            end
                        endcase
                        if (q.dummyLeft != 3'h0) begin
                            d.st = ST_DUMMY;
                        end else if (sfcf_is_read(q.opc)) begin
                            d.st = ST_DATA;
                            d.load = 1'b1;
                            d.rdTake = 1'b1;
                        end else if (sfcf_takes_data(q.opc)) begin
                            d.st = ST_DATA;
                        end else begin
                            d.st = ST_IGNORE;
                        end
                    end
                end
                ST_DUMMY: begin
                    d.bitCnt = q.bitCnt + CNT_W'(1);
                    if (q.bitCnt == LAST_OP_BIT) begin
                        d.bitCnt = '0;
                        d.dummyLeft = q.dummyLeft - 3'h1;
                        if (q.dummyLeft == 3'h1) begin
                            d.st = ST_DATA;
                            d.load = 1'b1;
                            d.rdTake = 1'b1;
                        end
                    end
                end
                ST_DATA: begin
                    d.dataBit = q.dataBit + 3'h1;
                    d.wrSh = {q.wrSh[6:0], link.siBit};
                    if (q.dataBit == LAST_DATA_BIT) begin
                        if (sfcf_is_read(q.opc)) begin
                            d.load = 1'b1;
                            d.rdTake = 1'b1;
                        end else begin
                            d.wrValid = 1'b1;
                            d.wrByte = {q.wrSh[6:0], link.siBit};
                        end
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    d.st = q.st;
                end
                default: d.st = ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // registers: reset holds every operation off
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.mode3 <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign link.load = q.load;
    assign link.loadByte = rdByte;

    // ==========================================================
    // outputs
    assign cmdValid = q.cmdValid;
    assign cmdOpcode = q.cmdOpc;
    assign cmdPage = q.cmdPage;
    assign cmdByte = q.cmdCol;
    assign rdTake = q.rdTake;
    assign wrValid = q.wrValid;
    assign wrByte = q.wrByte;
    assign spiMode3 = q.mode3;
    assign deepPowerDown = q.dpd;
    assign standby = (q.st == ST_IDLE) && !q.dpd;
    assign selectAllowed = (q.selCnt == SEL_LAST);
    assign writeAllowed = (q.wriCnt == WRI_LAST);
endmodule : sfcf_frame

// ==== testbench/sfcf_chk.sv ====
// port assertions for the command framer
`timescale 1ns/1ns
module sfcf_chk #(
    parameter int unsigned SELECT_DELAY = 10000,
    parameter int unsigned WRITE_INHIBIT = 200000
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic chipSelN,
    input wire logic serClk,
    input wire logic serOutEnN,
    input wire logic cmdValid,
    input wire logic [7:0] cmdOpcode,
    input wire logic rdTake,
    input wire logic wrValid,
    input wire logic spiMode3,
    input wire logic deepPowerDown,
    input wire logic standby,
    input wire logic selectAllowed,
    input wire logic writeAllowed
);
    // ==========================================================
    // helpers
    logic [17:0] upCnt_q;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) upCnt_q <= '0;
        else if (~&upCnt_q) upCnt_q <= upCnt_q + 18'h00001;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // clock held still long enough for the synchronised sample to land
    sequence s_sel_hi;
        $fell(chipSelN) && serClk ##1 serClk [*6];
    endsequence
    sequence s_sel_lo;
        $fell(chipSelN) && !serClk ##1 !serClk [*6];
    endsequence
    // ==========================================================
    // assertions
    a_reset_state: assert property ($fell(sys_rst) |-> spiMode3 && serOutEnN && standby)
        else $error("state after reset wrong");
    a_mode_three: assert property (s_sel_hi |=> spiMode3)
        else $error("mode 3 not selected");
    a_mode_zero: assert property (s_sel_lo |=> !spiMode3)
        else $error("mode 0 not selected");
    a_out_float: assert property (chipSelN [*6] |-> serOutEnN)
        else $error("output driven while deselected");
    a_drive_cause: assert property ($fell(serOutEnN) |-> $past(rdTake))
        else $error("output driven without read data");
    a_idle_quiet: assert property (chipSelN [*6] |-> !cmdValid && !rdTake && !wrValid)
        else $error("activity while deselected");
    a_sleep_wake: assert property (cmdValid && deepPowerDown |-> cmdOpcode == 8'hab)
        else $error("command accepted in deep power-down");
    a_select_time: assert property ((upCnt_q + 1 < SELECT_DELAY -> !selectAllowed) &&
        (upCnt_q > SELECT_DELAY + 1 -> selectAllowed)) else $error("select delay status wrong");
    a_write_time: assert property ((upCnt_q + 1 < WRITE_INHIBIT -> !writeAllowed) &&
        (upCnt_q > WRITE_INHIBIT + 1 -> writeAllowed)) else $error("write delay status wrong");
endmodule : sfcf_chk

// ==== testbench/sfcf_host.sv ====
// host model: drives select, serial clock and data, reads serial out
`timescale 1ns/1ns
module sfcf_host (
    input wire logic sys_clk,
    output logic chipSelN,
    output logic serClk,
    output logic serIn,
    input wire logic serOut,
    input wire logic serOutEnN
);
    initial begin
        chipSelN = 1'b1;
        serClk = 1'b1;
        serIn = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    // ==========================================================
    // one frame: n clocks, data read at the end of the low phase from clock dstart
    task automatic frame(input logic [95:0] bits, input int n, input int dstart, input logic idle,
        output logic [7:0] rx);
        serClk = idle;
        tick(4);
        chipSelN = 1'b0;
        tick(8);
        for (int i = 0; i < n; i++) begin
            serClk = 1'b0;
            serIn = bits[95 - i];
            tick(4);
            // the shift after a fall lands three cycles late, so sample just before the rise
            if (i >= dstart && i < dstart + 8) rx = {rx[6:0], serOutEnN ? 1'bx : serOut};
            serClk = 1'b1;
            tick(4);
        end
        serClk = idle;
        tick(4);
        chipSelN = 1'b1;
        // released line must not keep its last value
        serIn = ~serIn;
        tick(8);
    endtask : frame
endmodule : sfcf_host

// ==== testbench/tb_top.sv ====
// top testbench: host frames, command scoreboard and verdict
`timescale 1ns/1ns
module tb_top;
    import sfcf_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] rdByte = 8'h00;
    logic chipSelN, serClk, serIn, serOut, serOutEnN, cmdValid, rdTake, wrValid;
    logic spiMode3, deepPowerDown, standby, selectAllowed, writeAllowed;
    logic [7:0] cmdOpcode, wrByte, rx;
    logic [7:0] wrQ[$];
    logic [PAGE_W-1:0] cmdPage;
    logic [COL_W-1:0] cmdByte;
    logic [31:0] seed = 32'hebc5ff6b;
    logic [25:0] expQ[$];
    int n_mismatch = 0;
    int total_checks = 0;
    always #50 sys_clk = ~sys_clk;
    sfcf_frame #(.SELECT_DELAY(20), .WRITE_INHIBIT(50)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .chipSelN(chipSelN), .serClk(serClk), .serIn(serIn), .serOut(serOut), .serOutEnN(serOutEnN),
        .cmdValid(cmdValid), .cmdOpcode(cmdOpcode), .cmdPage(cmdPage), .cmdByte(cmdByte), .rdByte(rdByte),
        .rdTake(rdTake), .wrValid(wrValid), .wrByte(wrByte), .spiMode3(spiMode3), .deepPowerDown(deepPowerDown),
        .standby(standby), .selectAllowed(selectAllowed), .writeAllowed(writeAllowed));
    sfcf_host host_u (.sys_clk(sys_clk), .chipSelN(chipSelN), .serClk(serClk), .serIn(serIn),
        .serOut(serOut), .serOutEnN(serOutEnN));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [25:0] expect_cmd(input logic [7:0] op, input logic [23:0] a);
        case (op)
            8'h03, 8'h0b, 8'h82, 8'hd2, 8'he8: return {op, a[17:9], a[8:0]};
            8'h50: return {op, a[17:13], 4'h0, 9'h000};
            8'h53, 8'h58, 8'h60, 8'h81, 8'h83, 8'h88: return {op, a[17:9], 9'h000};
            8'h84, 8'hd1, 8'hd4: return {op, 9'h000, a[8:0]};
            default: return {op, 18'h00000};
        endcase
    endfunction : expect_cmd
    task automatic chk_cmd(input string what, input logic [25:0] e, input logic [25:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask : chk_cmd
    task automatic chk_val(input string what, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask : chk_val
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test
    // ==========================================================
    // scoreboard: pulses stand one cycle, so look mid-cycle
    always @(negedge sys_clk) begin
        if (cmdValid === 1'b1 && expQ.size() == 0) begin
            n_mismatch++;
            $display("unexpected cmdValid: expected none, seen %h", cmdOpcode);
        end else if (cmdValid === 1'b1) chk_cmd("command", expQ.pop_front(), {cmdOpcode, cmdPage, cmdByte});
        if (wrValid === 1'b1 && wrQ.size() == 0) begin
            n_mismatch++;
            $display("unexpected wrValid: expected none, seen %h", wrByte);
        end else if (wrValid === 1'b1) chk_val("wrByte", wrQ.pop_front(), wrByte);
    end
    task automatic run(input logic [7:0] op, input logic idle, input logic push);
        logic [95:0] bits;
        int na;
        int nd;
        seed = lfsr(lfsr(seed));
        na = (op inside {8'h9f, 8'hb9, 8'hab, 8'hd7}) ? 0 : 24;
        nd = (op inside {8'h0b, 8'hd4}) ? 8 : (op inside {8'hd2, 8'he8}) ? 32 : 0;
        bits = {op, seed[23:0], seed, ~seed};
        rdByte = seed[31:24];
        if (push && op inside {8'h82, 8'h84}) wrQ.push_back(bits[87 - na -: 8]);
        if (push) expQ.push_back(expect_cmd(op, bits[87:64]));
        host_u.frame(bits, 16 + na + nd, 8 + na + nd, idle, rx);
        if (push) begin
            if (op inside {8'h03, 8'h0b, 8'h77, 8'h9f, 8'hd1, 8'hd2, 8'hd4, 8'hd7, 8'he8}) begin
                chk_val("rdData", rdByte, rx);
            end
            chk_val("spiMode3", 8'(idle), 8'(spiMode3));
        end
    endtask : run
    // ==========================================================
    // main sequence
    initial begin
        automatic logic [7:0] ops[20] = '{8'h03, 8'h0b, 8'h50, 8'h53, 8'h58, 8'h60, 8'h77, 8'h7c, 8'h81, 8'h82,
            8'h83, 8'h84, 8'h88, 8'h9f, 8'hd1, 8'hd2, 8'hd4, 8'hd7, 8'he8, 8'hb9};
        repeat (12) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        chk_val("serOutEnN", 8'h01, 8'(serOutEnN));
        chk_val("spiMode3", 8'h01, 8'(spiMode3));
        chk_val("standby", 8'h01, 8'(standby));
        // no command before the write delay has run out
        for (int k = 0; k < 100 && writeAllowed !== 1'b1; k++) @(posedge sys_clk);
        #1;
        chk_val("writeAllowed", 8'h01, 8'(writeAllowed));
        chk_val("selectAllowed", 8'h01, 8'(selectAllowed));
        // a run-out wait is already counted: go straight to the report
        if (writeAllowed === 1'b1) begin
            foreach (ops[i]) run(ops[i], i[0], 1'b1);
            chk_val("deepPowerDown", 8'h01, 8'(deepPowerDown));
            chk_val("standby", 8'h00, 8'(standby));
            run(8'h03, 1'b0, 1'b0);
            run(8'hab, 1'b1, 1'b1);
            chk_val("deepPowerDown", 8'h00, 8'(deepPowerDown));
            host_u.frame({8'h0b, seed, 56'h0}, 12, 99, 1'b0, rx);
            run(8'h9f, 1'b0, 1'b1);
            chk_val("pending", 8'h00, 8'(expQ.size() + wrQ.size()));
        end
        end_of_test();
    end
endmodule : tb_top
bind sfcf_frame sfcf_chk #(.SELECT_DELAY(SELECT_DELAY), .WRITE_INHIBIT(WRITE_INHIBIT)) chk_u (.*);
